// *** dtc_timer_ctl.sv ***
// Timer control register with Wishbone slave and field decoding
// Contract
// RULE_01 - B edge select: pos, neg, both; 2 reserved
// RULE_02 - B freezes during debug halt when set
// RULE_03 - Stall ignored while processor runs normally
// RULE_04 - B enable gates counting or capture
// RULE_05 - A PWM invert bit inverts output
// RULE_06 - A trigger enable gates converter trigger
// RULE_07 - Converter must enable and select timer
// RULE_08 - RTC enable gates RTC counting
// RULE_09 - A edge select: pos, neg, both; 2 reserved
// RULE_10 - A freezes during debug halt when set
// RULE_11 - A enable gates counting or capture
// RULE_12 - Bit 7 reserved, reads as zero
`default_nettype none
`include "dtc_params.svh"
module dtc_timer_ctl (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Processor and timer signals
  input  wire logic        debug_halt_in,
  input  wire logic        timer_a_pin_in,
  input  wire logic        timer_b_pin_in,
  input  wire logic        timer_a_pwm_in,
  input  wire logic        timer_a_trigger_in,
  // Control outputs
  output logic             timer_a_run_out,
  output logic             timer_b_run_out,
  output logic             timer_a_edge_out,
  output logic             timer_b_edge_out,
  output logic             timer_a_pwm_out,
  output logic             timer_a_trigger_out,
  output logic             rtc_count_enable_out
);
  typedef struct packed {
    dtc_pkg::dtc_bus_state_t bus;
    logic [31:0]             rdata;
    logic [11:0]             timer_control;
    logic [2:0]              halt_sync;
    logic                    halted;
    logic [2:0]              a_sync;
    logic                    a_pin;
    logic [2:0]              b_sync;
    logic                    b_pin;
    logic                    pwm;
    logic                    trig;
    logic                    rtc;
  } dtc_ctl_state_t;

  dtc_ctl_state_t s_q;
  dtc_ctl_state_t s_d;
  dtc_half_if     a_if ();
  dtc_half_if     b_if ();
  logic           req;
  logic [31:0]    wmask;

  function automatic logic [31:0] dtc_byte_mask(input logic [3:0] sel);
    dtc_byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : dtc_byte_mask

  // Level follows only when stages two and three agree
  function automatic logic dtc_filter(input logic [2:0] sync, input logic held);
    dtc_filter = (sync[1] == sync[2]) ? sync[2] : held;
  endfunction : dtc_filter

  assign req   = wb_cyc_in & wb_stb_in;
  assign wmask = dtc_byte_mask(wb_sel_in) & `DTC_CTL_WMASK;

  always_comb
  begin
    s_d           = s_q;
    s_d.halt_sync = {s_q.halt_sync[1:0], debug_halt_in};
    s_d.halted    = dtc_filter(s_q.halt_sync, s_q.halted);
    s_d.a_sync    = {s_q.a_sync[1:0], timer_a_pin_in};
    s_d.a_pin     = dtc_filter(s_q.a_sync, s_q.a_pin);
    s_d.b_sync    = {s_q.b_sync[1:0], timer_b_pin_in};
    s_d.b_pin     = dtc_filter(s_q.b_sync, s_q.b_pin);
    unique case (s_q.bus)
      dtc_pkg::DTC_BUS_IDLE:
      begin
        if (req)
        begin
          s_d.bus   = dtc_pkg::DTC_BUS_ACK;
          s_d.rdata = 32'h0000_0000;
          if (wb_adr_in == `DTC_CTL_OFFSET)
          begin
            // Reserved bit 7 never stored, reads zero
            s_d.rdata = {20'h00000, s_q.timer_control}; // RULE_12
            if (wb_we_in)
              s_d.timer_control = 12'((s_q.timer_control & ~wmask[11:0]) | (wb_dat_in[11:0] & wmask[11:0]));
          end
          else if (wb_adr_in == `DTC_STATUS_OFFSET)
            s_d.rdata = {29'h00000000, s_q.halted, timer_b_run_out, timer_a_run_out};
        end
      end
      dtc_pkg::DTC_BUS_ACK:
        s_d.bus = dtc_pkg::DTC_BUS_IDLE;
    endcase
    s_d.pwm  = timer_a_pwm_in ^ s_q.timer_control[`DTC_TA_PWMINV_BIT]; // RULE_05
    // Converter still needs its own enable and source select
    s_d.trig = timer_a_trigger_in & s_q.timer_control[`DTC_TA_TRIG_BIT]; // RULE_06 RULE_07
    s_d.rtc  = s_q.timer_control[`DTC_RTC_EN_BIT]; // RULE_08
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q               <= '0;
      s_q.bus           <= dtc_pkg::DTC_BUS_IDLE;
      s_q.timer_control <= 12'(`DTC_CTL_RESET);
    end
    else
      s_q <= s_d;
  end

  // Half A configuration, one driver for the whole packed struct
  assign a_if.cfg          = '{enable:   s_q.timer_control[`DTC_TA_EN_BIT], // RULE_11
                               freeze:   s_q.timer_control[`DTC_TA_STALL_BIT], // RULE_10
                               edge_sel: s_q.timer_control[`DTC_TA_EDGE_LO +: 2]}; // RULE_09
  assign a_if.halted       = s_q.halted; // RULE_03
  assign a_if.sig_raw      = s_q.a_pin;
  // Half B configuration
  assign b_if.cfg          = '{enable:   s_q.timer_control[`DTC_TB_EN_BIT], // RULE_04
                               freeze:   s_q.timer_control[`DTC_TB_STALL_BIT], // RULE_02
                               edge_sel: s_q.timer_control[`DTC_TB_EDGE_LO +: 2]}; // RULE_01
  assign b_if.halted       = s_q.halted; // RULE_03
  assign b_if.sig_raw      = s_q.b_pin;

  dtc_half_gate u_gate_a (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .hif        (a_if.half)
  );

  dtc_half_gate u_gate_b (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .hif        (b_if.half)
  );

  // All outputs straight from flops
  assign wb_dat_out           = s_q.rdata;
  assign wb_ack_out           = (s_q.bus == dtc_pkg::DTC_BUS_ACK);
  assign timer_a_run_out      = a_if.run;
  assign timer_b_run_out      = b_if.run;
  assign timer_a_edge_out     = a_if.edge_hit;
  assign timer_b_edge_out     = b_if.edge_hit;
  assign timer_a_pwm_out      = s_q.pwm;
  assign timer_a_trigger_out  = s_q.trig;
  assign rtc_count_enable_out = s_q.rtc;
endmodule : dtc_timer_ctl
`default_nettype wire

// *** dtc_params.svh ***
// Constants for the dual timer control field block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_CTL_OFFSET      8'h0c
`define DTC_STATUS_OFFSET   8'h10
`define DTC_ADDR_W          8
`define DTC_CTL_RESET       32'h0000_0000
`define DTC_CTL_WMASK       32'h0000_0f7f
`define DTC_TA_EN_BIT       0
`define DTC_TA_STALL_BIT    1
`define DTC_TA_EDGE_LO      2
`define DTC_RTC_EN_BIT      4
`define DTC_TA_TRIG_BIT     5
`define DTC_TA_PWMINV_BIT   6
`define DTC_TB_EN_BIT       8
`define DTC_TB_STALL_BIT    9
`define DTC_TB_EDGE_LO      10
`define DTC_EDGE_POS        2'h0
`define DTC_EDGE_NEG        2'h1
`define DTC_EDGE_RSVD       2'h2
`define DTC_EDGE_BOTH       2'h3

`endif

// *** dtc_pkg.sv ***
// Types for the dual timer control field block
`default_nettype none
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_BUS_IDLE = 2'h0,
    DTC_BUS_ACK  = 2'h1
  } dtc_bus_state_t;

  typedef struct packed {
    logic       enable;
    logic       freeze;
    logic [1:0] edge_sel;
  } dtc_half_cfg_t;
endpackage : dtc_pkg
`default_nettype wire

// *** dtc_half_if.sv ***
// Per-half timer control carrier
`default_nettype none
interface dtc_half_if;
  dtc_pkg::dtc_half_cfg_t cfg;
  logic                   halted;
  logic                   sig_raw;
  logic                   run;
  logic                   edge_hit;
  modport ctl (output cfg, output halted, output sig_raw, input run, input edge_hit);
  modport half (input cfg, input halted, input sig_raw, output run, output edge_hit);
endinterface : dtc_half_if
`default_nettype wire

// *** dtc_half_gate.sv ***
// Run gating and edge detection for one timer half
`default_nettype none
`include "dtc_params.svh"
module dtc_half_gate (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Control carrier
  dtc_half_if.half  hif
);
  typedef struct packed {
    logic prev;
    logic run;
    logic hit;
  } dtc_gate_state_t;

  dtc_gate_state_t s_q;
  dtc_gate_state_t s_d;

  function automatic logic dtc_edge_match(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    unique case (sel)
      `DTC_EDGE_POS:  dtc_edge_match = rise;
      `DTC_EDGE_NEG:  dtc_edge_match = fall;
      `DTC_EDGE_BOTH: dtc_edge_match = rise | fall;
      // Reserved code detects nothing
      default:        dtc_edge_match = 1'b0;
    endcase
  endfunction : dtc_edge_match

  always_comb
  begin
    s_d      = s_q;
    s_d.prev = hif.sig_raw;
    // Stall only matters while halted
    s_d.run  = hif.cfg.enable & ~(hif.cfg.freeze & hif.halted);
    s_d.hit  = hif.cfg.enable & dtc_edge_match(hif.cfg.edge_sel, s_q.prev, hif.sig_raw);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign hif.run      = s_q.run;
  assign hif.edge_hit = s_q.hit;
endmodule : dtc_half_gate
`default_nettype wire

// *** dtc_timer_ctl_checker.sv ***
// Assertion checker for the timer control block
`default_nettype none
module dtc_timer_ctl_checker (
  // Watched ports
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  input  wire logic        debug_halt_in,
  input  wire logic        timer_a_trigger_in,
  input  wire logic        timer_a_run_out,
  input  wire logic        timer_b_run_out,
  input  wire logic        timer_a_trigger_out,
  input  wire logic        rtc_count_enable_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_ack_on_request: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
  a_ack_needs_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("stray ack");
  a_bit7_reads_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h0c |-> !wb_dat_out[7])
    else $error("bit 7 set");
  a_upper_reads_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h0c |-> wb_dat_out[31:12] == 20'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h20 |-> wb_dat_out == 32'h0)
    else $error("unmapped read");
  a_trigger_gated: assert property (timer_a_trigger_out |-> $past(timer_a_trigger_in))
    else $error("trigger without cause");
  a_rtc_by_write: assert property ($changed(rtc_count_enable_out) |-> $past(wb_ack_out) || $past(wb_ack_out, 2))
    else $error("rtc moved");
  // Halt filter needs up to five cycles, so eight quiet cycles are enough
  a_run_a_quiet: assert property ((!wb_ack_out && !debug_halt_in)[*8] |-> $stable(timer_a_run_out))
    else $error("run a moved");
  a_run_b_quiet: assert property ((!wb_ack_out && !debug_halt_in)[*8] |-> $stable(timer_b_run_out))
    else $error("run b moved");
  c_write: cover property (wb_ack_out && wb_we_in);
  c_freeze: cover property ($fell(timer_a_run_out) && debug_halt_in);
  c_trigger: cover property (timer_a_trigger_out);
endmodule : dtc_timer_ctl_checker
bind dtc_timer_ctl dtc_timer_ctl_checker u_chk (.ref_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_dat_out, .wb_ack_out, .debug_halt_in, .timer_a_trigger_in, .timer_a_run_out, .timer_b_run_out,
  .timer_a_trigger_out, .rtc_count_enable_out);
`default_nettype wire

// *** dtc_timer_ctl_tb_top.sv ***
// Self-checking testbench for the timer control block
`default_nettype none
module dtc_timer_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 0, rst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, debug_halt_in = 0;
  logic timer_a_pin_in = 0, timer_b_pin_in = 0, timer_a_pwm_in = 0, timer_a_trigger_in = 0;
  logic [7:0] wb_adr_in = 8'h0;
  logic [3:0] wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
  logic wb_ack_out, timer_a_run_out, timer_b_run_out, timer_a_edge_out, timer_b_edge_out;
  logic timer_a_pwm_out, timer_a_trigger_out, rtc_count_enable_out;
  int error_cnt = 0, tests_run = 0, ea = 0, eb = 0;
  dtc_timer_ctl dut (.*);
  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    ea <= ea + int'(timer_a_edge_out);
    eb <= eb + int'(timer_b_edge_out);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
    do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      $display("[FAIL] %0t no bus answer", $time);
      error_cnt++;
    end
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask : wb
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : idle
  task automatic t_regs;
    wb(0, 8'h0c, 0); chk(rd, 32'h0);
    wb(1, 8'h0c, 32'hffff_ffff); wb(0, 8'h0c, 0); chk(rd, 32'h0000_0f7f);
    wb(1, 8'h20, 32'h0); wb(0, 8'h20, 0); chk(rd, 32'h0);
    wb_sel_in <= 4'h1;
    wb(1, 8'h0c, 32'h0);
    wb_sel_in <= 4'hf;
    wb(0, 8'h0c, 0); chk(rd, 32'h0000_0f00);
  endtask : t_regs
  task automatic t_outs;
    @(posedge ref_clk_in); {timer_a_pwm_in, timer_a_trigger_in} <= 2'b11;
    wb(1, 8'h0c, 32'h70); idle(3);
    chk(32'({timer_a_pwm_out, timer_a_trigger_out, rtc_count_enable_out}), 32'h3);
    wb(1, 8'h0c, 32'h0); idle(3);
    chk(32'({timer_a_pwm_out, timer_a_trigger_out, rtc_count_enable_out}), 32'h4);
  endtask : t_outs
  task automatic t_stall(input logic [31:0] v, input logic [1:0] halted_run);
    wb(1, 8'h0c, v); @(posedge ref_clk_in); debug_halt_in <= 1'b1; idle(10);
    chk(32'({timer_b_run_out, timer_a_run_out}), 32'(halted_run));
    wb(0, 8'h10, 0); chk(rd, 32'({1'b1, halted_run}));
    @(posedge ref_clk_in); debug_halt_in <= 1'b0; idle(10);
    chk(32'({timer_b_run_out, timer_a_run_out}), 32'({v[8], v[0]}));
  endtask : t_stall
  task automatic t_edges;
    for (int c = 0; c < 4; c++)
    begin
      wb(1, 8'h0c, 32'h101 | (c << 10) | (c << 2)); idle(8); ea = 0; eb = 0;
      @(posedge ref_clk_in); {timer_a_pin_in, timer_b_pin_in} <= 2'b11; idle(10);
      chk(ea, 32'(c == 0 || c == 3));
      chk(eb, 32'(c == 0 || c == 3));
      ea = 0; eb = 0;
      @(posedge ref_clk_in); {timer_a_pin_in, timer_b_pin_in} <= 2'b00; idle(10);
      chk(ea, 32'(c == 1 || c == 3));
      chk(eb, 32'(c == 1 || c == 3));
    end
  endtask : t_edges
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Whole run needs well under 2000 cycles
  initial
  begin
    #20us; error_cnt++; wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs(); t_outs();
    t_stall(32'h103, 2'b10); t_stall(32'h301, 2'b01); t_stall(32'h202, 2'b00);
    t_edges();
    wrap_up();
  end
endmodule : dtc_timer_ctl_tb_top
`default_nettype wire
